// file: verilog/isolated_dio_defs.vh
// What this block does
// - sixteen inputs read as two eight-bit ports
// - sixteen outputs driven from two eight-bit ports
// - conducting input line reads as one
// - output bit one switches transistor on
// - outputs cleared to zero at reset
// - output readback leaves outputs unchanged
// - filter passes level only after stable time
// - filter setting 0 to 20, 0 bypasses; register takes 0 to 31 with no clamp
// - stable time two to n base periods
// - one filter time for all inputs
// - any input may raise an interrupt
// - edges taken from filtered values when filtering
// - per-input mask, all masked after reset
// - edge select zero: trigger on zero-to-one
// - edge select one: trigger on one-to-zero
// - edge selects cleared to zero at reset
// - status per input, cleared on read
// - masked input never sets status; reset clears
`ifndef ISOLATED_DIO_DEFS_VH
`define ISOLATED_DIO_DEFS_VH

`define DIO_OFS_INPUT 12'h000
`define DIO_OFS_OUTPUT 12'h004
`define DIO_OFS_FILTER 12'h008
`define DIO_OFS_MASK 12'h00c
`define DIO_OFS_EDGE 12'h010
`define DIO_OFS_STATUS 12'h014

`define DIO_RST_OUTPUT 16'h0000
`define DIO_RST_FILTER 5'h00
`define DIO_RST_MASK 16'hffff
`define DIO_RST_EDGE 16'h0000
`define DIO_RST_STATUS 16'h0000

`define DIO_PORT0_LSB 0
`define DIO_PORT1_LSB 8
`define DIO_FILTER_LSB 0
`define DIO_FILTER_MAX 20

`define DIO_CLK_HZ 50000000
`define DIO_BASE_HZ 8000000

`define DIO_RESP_OKAY 2'b00
`define DIO_RESP_SLVERR 2'b10

`endif

// file: verilog/base_tick_gen.v
`timescale 1ns/1ps
`include "isolated_dio_defs.vh"
module base_tick_gen (
    input wire clk,
    input wire rstn,
    output reg tick
);
    // fractional accumulator: 8 ticks every 50 clocks, exact on average
    localparam integer STEP_I = `DIO_BASE_HZ / 1000000;
    localparam integer MODULUS_I = `DIO_CLK_HZ / 1000000;
    localparam [6:0] STEP = STEP_I[6:0];
    localparam [6:0] MODULUS = MODULUS_I[6:0];
    reg [6:0] acc_r;
    wire [6:0] accSum = acc_r + STEP;

    always @(posedge clk) begin
        if (!rstn) begin
            acc_r <= 7'h00;
            tick <= 1'b0;
        end else if (accSum >= MODULUS) begin
            acc_r <= accSum - MODULUS;
            tick <= 1'b1;
        end else begin
            acc_r <= accSum;
            tick <= 1'b0;
        end
    end
endmodule

// file: verilog/isolated_dio.v
`timescale 1ns/1ps
`include "isolated_dio_defs.vh"
module isolated_dio (
    input wire clk,
    input wire rstn,
    // isolated lines, logical level: one means conducting
    input wire [15:0] isolatedInputLine,
    output wire [15:0] isolatedOutputLine,
    output reg irq,
    // axi4-lite slave
    input wire [11:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////
    // register state

    reg [15:0] outData_r;
    reg [4:0] filterSel_r;
    reg [15:0] intMask_r;
    reg [15:0] edgeSel_r;
    reg [15:0] intStatus_r;
    wire [15:0] intStatus_nxt;
    reg [15:0] filtPrev_r;
    wire [15:0] filtVec;
    wire baseTick;

    assign isolatedOutputLine = outData_r;

    ////////////////////////////////////////////////////////////////////////
    // write channel

    reg [11:0] wrAddr_r;
    reg awHeld_r;
    reg [31:0] wrData_r;
    reg [3:0] wrStrb_r;
    reg wHeld_r;
    wire wrGo = awHeld_r && wHeld_r && !s_axi_bvalid;
    wire [11:0] wrWord = {wrAddr_r[11:2], 2'b00};

    // awready and wready only high while that half is still empty
    always @(posedge clk) begin
        if (!rstn) begin
            s_axi_awready <= 1'b0;
            awHeld_r <= 1'b0;
            wrAddr_r <= 12'h000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wrAddr_r <= s_axi_awaddr;
                awHeld_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end else if (wrGo) begin
                awHeld_r <= 1'b0;
                s_axi_awready <= 1'b0;
            end else begin
                s_axi_awready <= !awHeld_r && !s_axi_bvalid;
            end
        end
    end

    // data half is taken on its own, before or after the address
    always @(posedge clk) begin
        if (!rstn) begin
            s_axi_wready <= 1'b0;
            wHeld_r <= 1'b0;
            wrData_r <= 32'h00000000;
            wrStrb_r <= 4'h0;
        end else begin
            if (s_axi_wvalid && s_axi_wready) begin
                wrData_r <= s_axi_wdata;
                wrStrb_r <= s_axi_wstrb;
                wHeld_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end else if (wrGo) begin
                wHeld_r <= 1'b0;
                s_axi_wready <= 1'b0;
            end else begin
                s_axi_wready <= !wHeld_r && !s_axi_bvalid;
            end
        end
    end

    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge16[7:0] = strb[0] ? data[7:0] : old[7:0];
            merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
        end
    endfunction

    reg wrOutput;
    reg wrFilter;
    reg wrMask;
    reg wrEdge;
    reg wrMapped;

    // decode once, so at most one register strobe per write
    always @* begin
        wrOutput = 1'b0;
        wrFilter = 1'b0;
        wrMask = 1'b0;
        wrEdge = 1'b0;
        wrMapped = 1'b1;
        case (wrWord)
            `DIO_OFS_OUTPUT: begin
                wrOutput = wrGo;
            end
            `DIO_OFS_FILTER: begin
                wrFilter = wrGo;
            end
            `DIO_OFS_MASK: begin
                wrMask = wrGo;
            end
            `DIO_OFS_EDGE: begin
                wrEdge = wrGo;
            end
            `DIO_OFS_INPUT, `DIO_OFS_STATUS: begin
                // read-only words take no write
                wrMapped = 1'b1;
            end
            default: begin
                wrMapped = 1'b0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DIO_RESP_OKAY;
        end else if (wrGo) begin
            s_axi_bvalid <= 1'b1;
            // writes to read-only words are dropped but answered okay
            s_axi_bresp <= wrMapped ? `DIO_RESP_OKAY : `DIO_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DIO_RESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers

    always @(posedge clk) begin
        if (!rstn) begin
            outData_r <= `DIO_RST_OUTPUT;
        end else if (wrOutput) begin
            outData_r <= merge16(outData_r, wrData_r, wrStrb_r);
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            filterSel_r <= `DIO_RST_FILTER;
        end else if (wrFilter && wrStrb_r[0]) begin
            // no clamp: settings above the top value are left to software
            filterSel_r <= wrData_r[`DIO_FILTER_LSB+4:`DIO_FILTER_LSB];
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            intMask_r <= `DIO_RST_MASK;
        end else if (wrMask) begin
            intMask_r <= merge16(intMask_r, wrData_r, wrStrb_r);
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            edgeSel_r <= `DIO_RST_EDGE;
        end else if (wrEdge) begin
            edgeSel_r <= merge16(edgeSel_r, wrData_r, wrStrb_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel

    wire rdGo = s_axi_arvalid && s_axi_arready;
    wire [11:0] rdWord = {s_axi_araddr[11:2], 2'b00};
    reg [31:0] rdMux;
    reg rdMapped;

    always @* begin
        rdMux = 32'h00000000;
        rdMapped = 1'b1;
        case (rdWord)
            `DIO_OFS_INPUT: begin
                // port 0 in the low byte, port 1 in the next
                rdMux[`DIO_PORT0_LSB+7:`DIO_PORT0_LSB] = filtVec[7:0];
                rdMux[`DIO_PORT1_LSB+7:`DIO_PORT1_LSB] = filtVec[15:8];
            end
            `DIO_OFS_OUTPUT: begin
                rdMux[15:0] = outData_r;
            end
            `DIO_OFS_FILTER: begin
                rdMux[`DIO_FILTER_LSB+4:`DIO_FILTER_LSB] = filterSel_r;
            end
            `DIO_OFS_MASK: begin
                rdMux[15:0] = intMask_r;
            end
            `DIO_OFS_EDGE: begin
                rdMux[15:0] = edgeSel_r;
            end
            `DIO_OFS_STATUS: begin
                rdMux[15:0] = intStatus_r;
            end
            default: begin
                rdMapped = 1'b0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DIO_RESP_OKAY;
        end else if (rdGo) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdMapped ? `DIO_RESP_OKAY : `DIO_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // digital filter

    base_tick_gen u_tick (
        .clk(clk),
        .rstn(rstn),
        .tick(baseTick)
    );

    // one limit shared by all inputs; shifts beyond the counter width leave a zero limit
    wire bypass = (filterSel_r == 5'h00);
    wire [20:0] stableLimit = 21'h000001 << filterSel_r;

    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_filt
            reg lastSample_r;
            reg filtQ_r;
            reg [20:0] stableCnt_r;
            wire same = (isolatedInputLine[i] == lastSample_r);
            assign filtVec[i] = filtQ_r;
            always @(posedge clk) begin
                if (!rstn) begin
                    lastSample_r <= 1'b0;
                    filtQ_r <= 1'b0;
                    stableCnt_r <= 21'h000000;
                end else begin
                    lastSample_r <= isolatedInputLine[i];
                    if (!same) begin
                        stableCnt_r <= 21'h000000;
                    end else if (baseTick && (stableCnt_r < stableLimit)) begin
                        stableCnt_r <= stableCnt_r + 21'h000001;
                    end
                    if (bypass) begin
                        filtQ_r <= isolatedInputLine[i];
                    end else if (same && (stableCnt_r >= stableLimit)) begin
                        filtQ_r <= lastSample_r;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // interrupt edges and status

    wire statusRead = rdGo && (rdWord == `DIO_OFS_STATUS);
    wire [15:0] setEv;

    // one slice per input: edge pick, mask gate, clear on read
    genvar b;
    generate
        for (b = 0; b < 16; b = b + 1) begin : g_irq
            wire riseEv = filtVec[b] && !filtPrev_r[b];
            wire fallEv = !filtVec[b] && filtPrev_r[b];
            reg edgeEv;

            always @* begin
                edgeEv = 1'b0;
                if (edgeSel_r[b]) begin
                    edgeEv = fallEv;
                end else begin
                    edgeEv = riseEv;
                end
            end

            // masked inputs never reach the status bit
            assign setEv[b] = edgeEv && !intMask_r[b];
            // a fresh event in the read cycle survives the clear
            assign intStatus_nxt[b] = setEv[b] || (intStatus_r[b] && !statusRead);
        end
    endgenerate

    always @(posedge clk) begin
        if (!rstn) begin
            filtPrev_r <= 16'h0000;
            intStatus_r <= `DIO_RST_STATUS;
        end else begin
            filtPrev_r <= filtVec;
            intStatus_r <= intStatus_nxt;
        end
    end

    // registered so the request falls in the same edge as the clear
    always @(posedge clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(intStatus_nxt & ~intMask_r);
        end
    end

endmodule

// file: dv/ext_devices.sv
`timescale 1ns/1ps
module ext_devices (
    input wire clk,
    input wire [15:0] level,
    input wire [15:0] bounce,
    output logic [15:0] isolatedInputLine
);
    logic phase_r = 1'b0;
    initial isolatedInputLine = 16'h0000;
    // chatter flips every clock, shorter than any filter time
    always @(posedge clk) begin
        phase_r <= ~phase_r;
        isolatedInputLine <= level ^ (bounce & {16{phase_r}});
    end
endmodule

// file: dv/dio_checker.sv
`timescale 1ns/1ps
module dio_checker (
    input wire clk,
    input wire rstn,
    input wire [15:0] isolatedOutputLine,
    input wire irq,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence wrTake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wrAnswer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    ////////////////////////////////////////////////////////////////
    a_out_reset: assert property (disable iff (1'b0) !rstn |=> isolatedOutputLine == 0)
        else $error("outputs not cleared by reset");
    a_irq_reset: assert property (disable iff (1'b0) !rstn |=> !irq)
        else $error("irq not cleared by reset");
    a_out_only_write: assert property ($changed(isolatedOutputLine) |-> $rose(s_axi_bvalid))
        else $error("outputs moved without a write");
    a_irq_keeps: assert property (irq && s_axi_awready && !(s_axi_arvalid && s_axi_arready)
        |=> irq)
        else $error("irq dropped without status read");
    a_write_answer: assert property (wrTake |=> wrAnswer)
        else $error("write answer late");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
`include "isolated_dio_defs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] level = 16'h0000;
    logic [15:0] bounce = 16'h0000;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] isolatedInputLine, isolatedOutputLine;
    logic [31:0] rdat;
    logic [1:0] rrsp;
    logic [15:0] pat [4] = '{16'h0001, 16'h8000, 16'ha55a, 16'h00ff};
    int mismatches = 0, tests_run = 0, cyc = 0;
    always #10 clk = ~clk;
    ext_devices ext (.clk, .level, .bounce, .isolatedInputLine);
    isolated_dio DUT (.clk, .rstn, .isolatedInputLine, .isolatedOutputLine, .irq,
        .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    ////////////////////////////////////////////////////////////////
    task end_sim;
        begin
            $display("compares %0d mismatches %0d", tests_run, mismatches);
            if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            end_sim;
        end
    end
    // wr and rd waits are bounded only by the global cycle ceiling
    task wr(input logic [11:0] a, input logic [31:0] d);
        begin
            @(posedge clk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do begin
                @(posedge clk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
            end while (s_axi_bvalid !== 1'b1);
            s_axi_bready <= 1'b0;
        end
    endtask
    task rd(input logic [11:0] a);
        begin
            @(posedge clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do begin
                @(posedge clk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
            end while (s_axi_rvalid !== 1'b1);
            rdat = s_axi_rdata;
            rrsp = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e);
        begin
            rd(a);
            `CHK(rdat, e)
        end
    endtask
    // bounded: a stuck irq shows up as a compare, not a hang
    task wait_irq;
        int n;
        begin
            for (n = 0; n < 30 && irq !== 1'b1; n++) @(posedge clk);
            `CHK(irq, 1'b1)
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rchk(`DIO_OFS_OUTPUT, 32'h0);
        rchk(`DIO_OFS_FILTER, 32'h0);
        rchk(`DIO_OFS_MASK, 32'h0000ffff);
        rchk(`DIO_OFS_EDGE, 32'h0);
        rchk(`DIO_OFS_STATUS, 32'h0);
        rd(12'h100);
        `CHK(rrsp, 2'b10)
        $display("test reset done");
        foreach (pat[i]) begin
            wr(`DIO_OFS_OUTPUT, {16'h0000, pat[i]});
            `CHK(isolatedOutputLine, pat[i])
            rchk(`DIO_OFS_OUTPUT, {16'h0000, pat[i]});
            `CHK(isolatedOutputLine, pat[i])
        end
        level <= 16'h8c31;
        repeat (4) @(posedge clk);
        rchk(`DIO_OFS_INPUT, 32'h00008c31);
        level <= 16'h0000;
        repeat (4) @(posedge clk);
        $display("test data done");
        wr(`DIO_OFS_MASK, 32'h0000fffc);
        wr(`DIO_OFS_EDGE, 32'h00000002);
        level <= 16'h0007;
        wait_irq;
        rchk(`DIO_OFS_STATUS, 32'h1);
        `CHK(irq, 1'b0)
        level <= 16'h0000;
        wait_irq;
        rchk(`DIO_OFS_STATUS, 32'h2);
        $display("test irq done");
        wr(`DIO_OFS_EDGE, 32'h0);
        wr(`DIO_OFS_MASK, 32'h0000fff7);
        wr(`DIO_OFS_FILTER, 32'h2);
        bounce <= 16'h0008;
        repeat (40) @(posedge clk);
        bounce <= 16'h0000;
        repeat (40) @(posedge clk);
        rchk(`DIO_OFS_INPUT, 32'h0);
        rchk(`DIO_OFS_STATUS, 32'h0);
        level <= 16'h0108;
        repeat (8) @(posedge clk);
        rchk(`DIO_OFS_INPUT, 32'h0);
        repeat (40) @(posedge clk);
        rchk(`DIO_OFS_INPUT, 32'h00000108);
        rchk(`DIO_OFS_STATUS, 32'h8);
        $display("test filter done");
        end_sim;
    end
endmodule
bind isolated_dio dio_checker chk (.clk, .rstn, .isolatedOutputLine, .irq, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
